// ---- hw/vtp_defines.vh ----
`ifndef VTP_DEFINES_VH
`define VTP_DEFINES_VH

// Register map: I/O offset 0x35 is not a multiple of four, so it is an index.
`define VTP_CTRL_INDEX        8'h35
`define VTP_CTRL_DATA_ADDR    8'h55
`define VTP_CTRL_BYTE_ADDR    12'h0d4
`define VTP_CTRL_RESET        8'h00

// Field positions inside the control register.
`define VTP_BIT_UNLOCK        0
`define VTP_BIT_SELECT        1
`define VTP_BIT_PULLUP        4
`define VTP_CTRL_WR_MASK      8'h13

// Unlock window length in CPU cycles.
`define VTP_UNLOCK_CYCLES     3'h4

// Program word addresses (14-bit word space).
`define VTP_FLASH_START       14'h0000
`define VTP_VECTOR_OFFSET     14'h0002
`define VTP_FLASH_WORDS       15'h4000

// Boot section sizes in words, indexed by the boot size fuse code.
`define VTP_BOOT_WORDS_SZ0    15'h0800
`define VTP_BOOT_WORDS_SZ1    15'h0400
`define VTP_BOOT_WORDS_SZ2    15'h0200
`define VTP_BOOT_WORDS_SZ3    15'h0100

`endif

// ---- hw/vtp_boot_addr.v ----
`timescale 1ns/1ps
`include "vtp_defines.vh"

// Maps the boot size fuse code to the first word of the boot section.
module vtp_boot_addr (
   input  wire [1:0]  boot_size_fuses,
   output reg  [13:0] boot_start
);
   reg [14:0] words;
   reg [14:0] diff;

   always @* begin
      case (boot_size_fuses)
         2'h0: words = `VTP_BOOT_WORDS_SZ0;
         2'h1: words = `VTP_BOOT_WORDS_SZ1;
         2'h2: words = `VTP_BOOT_WORDS_SZ2;
         default: words = `VTP_BOOT_WORDS_SZ3;
      endcase
      // The section always ends at the top of flash, so the start never needs bit 14.
      diff       = `VTP_FLASH_WORDS - words;
      boot_start = diff[13:0];
   end
endmodule // vtp_boot_addr

// ---- hw/vtp_ctrl.v ----
// Overview of operation
// [RL1] Select bit clear puts vectors at flash start, set puts them at boot start.
// [RL2] Boot section start address comes from the boot size fuses.
// [RL3] Software writes unlock one, then select with unlock zero within four cycles.
// [RL4] Interrupts are blocked from unlock until after the instruction after select write.
// [RL5] Without a select write, interrupts stay blocked exactly four cycles.
// [RL6] Automatic blocking never touches the global interrupt enable flag.
// [RL7] Unlock bit clears four cycles after set, or on the select write.
// [RL8] Boot vectors plus app lock bit 2 disable interrupts in the application section.
// [RL9] App vectors plus boot lock bit 2 disable interrupts in the boot section.
// [RL10] Eight-bit control register, reset zero, bits 4, 1 and 0 writable.
// [RL11] With a 2K boot section relocated vectors run 0x3C02 to 0x3C32.
// [RL12] Boot reset fuse programmed with 2K boot starts execution at 0x3C00.
// [RL13] Reset address and vector start follow boot reset fuse and select bit.
// [RL14] A select write outside the unlock window leaves the select bit unchanged.
//
// The APB register port was left to the implementer.
`timescale 1ns/1ps
`include "vtp_defines.vh"

module vtp_ctrl (
   input  wire        pclk,
   input  wire        presetn,
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [11:0] paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output reg         pready,
   output reg         pslverr,
   input  wire [1:0]  boot_size_fuses,
   input  wire        boot_reset_fuse,
   input  wire        app_section_lock_b2,
   input  wire        boot_section_lock_b2,
   input  wire        exec_in_boot,
   input  wire        instr_done,
   output reg         irq_block,
   output reg         pullup_disable,
   output reg         vector_base_select,
   output reg  [13:0] vector_base_addr,
   output reg  [13:0] reset_addr
);
   reg  [7:0]  ctrl_reg;
   reg  [2:0]  unlock_cnt_reg;
   reg  [2:0]  unlock_cnt_next;
   reg  [1:0]  hold_state_reg;
   reg  [1:0]  hold_state_next;
   reg  [7:0]  ctrl_next;
   reg  [2:0]  fuse_sync1_reg;
   reg  [2:0]  fuse_sync2_reg;
   reg  [2:0]  fuse_sync3_reg;
   reg  [2:0]  fuse_stable_reg;
   reg  [1:0]  size_sync1_reg;
   reg  [1:0]  size_sync2_reg;
   reg  [1:0]  size_sync3_reg;
   reg  [1:0]  size_stable_reg;
   wire [13:0] boot_start;
   wire        acc;
   wire        hit;
   wire        wr_ctrl;
   wire        sel_write;
   wire        unlock_open;
   reg         block_now;

   localparam HOLD_IDLE  = 2'h0;
   localparam HOLD_WAIT  = 2'h1;
   localparam HOLD_INSTR = 2'h2;

   assign acc         = psel & penable & ~pready;
   assign hit         = (paddr == `VTP_CTRL_BYTE_ADDR);
   assign wr_ctrl     = acc & pwrite & hit;
   assign unlock_open = (unlock_cnt_reg != 3'h0);
   // A write with unlock zero inside the window counts as the select write.
   assign sel_write   = wr_ctrl & unlock_open & ~pwdata[`VTP_BIT_UNLOCK];

   // Fuse and lock levels come from outside; changes count when stages agree.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fuse_sync1_reg  <= 3'h7;
         fuse_sync2_reg  <= 3'h7;
         fuse_sync3_reg  <= 3'h7;
         fuse_stable_reg <= 3'h7;
         size_sync1_reg  <= 2'h0;
         size_sync2_reg  <= 2'h0;
         size_sync3_reg  <= 2'h0;
         size_stable_reg <= 2'h0;
      end else begin
         fuse_sync1_reg <= {boot_reset_fuse, app_section_lock_b2, boot_section_lock_b2};
         fuse_sync2_reg <= fuse_sync1_reg;
         fuse_sync3_reg <= fuse_sync2_reg;
         if (fuse_sync2_reg == fuse_sync3_reg) begin
            fuse_stable_reg <= fuse_sync3_reg;
         end
         size_sync1_reg <= boot_size_fuses;
         size_sync2_reg <= size_sync1_reg;
         size_sync3_reg <= size_sync2_reg;
         if (size_sync2_reg == size_sync3_reg) begin
            size_stable_reg <= size_sync3_reg;
         end
      end
   end

   // [RL2] Boot start lookup.
   vtp_boot_addr u_boot_addr (
      .boot_size_fuses (size_stable_reg),
      .boot_start      (boot_start)
   );

   always @* begin
      ctrl_next       = ctrl_reg;
      unlock_cnt_next = unlock_cnt_reg;
      // [RL7] Unlock self clear.
      if (unlock_open) begin
         unlock_cnt_next = unlock_cnt_reg - 3'h1;
         if (unlock_cnt_reg == 3'h1) begin
            ctrl_next[`VTP_BIT_UNLOCK] = 1'b0;
         end
      end
      if (wr_ctrl) begin
         ctrl_next[`VTP_BIT_PULLUP] = pwdata[`VTP_BIT_PULLUP];
         if (sel_write) begin
            // [RL3] Select write inside window.
            ctrl_next[`VTP_BIT_SELECT] = pwdata[`VTP_BIT_SELECT];
            ctrl_next[`VTP_BIT_UNLOCK] = 1'b0;
            unlock_cnt_next            = 3'h0;
         end else if (pwdata[`VTP_BIT_UNLOCK]) begin
            // [RL14] Select kept when window is closed.
            ctrl_next[`VTP_BIT_UNLOCK] = 1'b1;
            unlock_cnt_next            = `VTP_UNLOCK_CYCLES;
         end
      end
   end

   always @* begin
      hold_state_next = hold_state_reg;
      case (hold_state_reg)
         HOLD_IDLE: begin
            if (wr_ctrl & pwdata[`VTP_BIT_UNLOCK] & ~unlock_open) begin
               hold_state_next = HOLD_WAIT;
            end
         end
         HOLD_WAIT: begin
            // [RL4] Hold past next instruction.
            if (sel_write) begin
               hold_state_next = HOLD_INSTR;
            end else if (unlock_cnt_reg == 3'h1) begin
               // [RL5] Four cycle release.
               hold_state_next = HOLD_IDLE;
            end
         end
         HOLD_INSTR: begin
            if (instr_done) begin
               hold_state_next = HOLD_IDLE;
            end
         end
         default: hold_state_next = HOLD_IDLE;
      endcase
   end

   always @* begin
      // [RL6] Only the block output, never the status flag.
      block_now = (hold_state_next != HOLD_IDLE);
      // [RL8] App lock gating.
      if (ctrl_next[`VTP_BIT_SELECT] & ~fuse_stable_reg[1] & ~exec_in_boot) begin
         block_now = 1'b1;
      end
      // [RL9] Boot lock gating.
      if (~ctrl_next[`VTP_BIT_SELECT] & ~fuse_stable_reg[0] & exec_in_boot) begin
         block_now = 1'b1;
      end
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_reg           <= `VTP_CTRL_RESET;
         unlock_cnt_reg     <= 3'h0;
         hold_state_reg     <= HOLD_IDLE;
         irq_block          <= 1'b0;
         pullup_disable     <= 1'b0;
         vector_base_select <= 1'b0;
         vector_base_addr   <= `VTP_VECTOR_OFFSET;
         reset_addr         <= `VTP_FLASH_START;
         prdata             <= 32'h0;
         pready             <= 1'b0;
         pslverr            <= 1'b0;
      end else begin
         // [RL10] Register storage.
         ctrl_reg           <= ctrl_next & `VTP_CTRL_WR_MASK;
         unlock_cnt_reg     <= unlock_cnt_next;
         hold_state_reg     <= hold_state_next;
         irq_block          <= block_now;
         pullup_disable     <= ctrl_next[`VTP_BIT_PULLUP];
         vector_base_select <= ctrl_next[`VTP_BIT_SELECT];
         // [RL1] Vector base choice.
         // [RL11] Entries follow base plus two.
         if (ctrl_next[`VTP_BIT_SELECT]) begin
            vector_base_addr <= boot_start + `VTP_VECTOR_OFFSET;
         end else begin
            vector_base_addr <= `VTP_FLASH_START + `VTP_VECTOR_OFFSET;
         end
         // [RL12] Reset address choice.
         // [RL13] Fuse one means flash start.
         reset_addr <= fuse_stable_reg[2] ? `VTP_FLASH_START : boot_start;
         pready     <= acc;
         pslverr    <= acc & ~hit;
         if (acc & ~pwrite & hit) begin
            prdata <= {24'h0, ctrl_reg};
         end else begin
            prdata <= 32'h0;
         end
      end
   end
endmodule // vtp_ctrl

// ---- tb/vtp_ctrl_monitor.sv ----
`timescale 1ns/1ps
module vtp_ctrl_monitor (
   input wire        pclk,
   input wire        presetn,
   input wire        psel,
   input wire        penable,
   input wire        pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   input wire [31:0] prdata,
   input wire        pready,
   input wire        pslverr,
   input wire        app_section_lock_b2,
   input wire        boot_section_lock_b2,
   input wire        irq_block,
   input wire        vector_base_select,
   input wire [13:0] vector_base_addr
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence taken_s;
      psel && penable && !pready;
   endsequence
   sequence unlock_s;
      pready && pwrite && paddr == 12'h0d4 && pwdata[0];
   endsequence
   answer_next_a: assert property (taken_s |=> pready)
      else $error("no answer after access");
   ready_pulse_a: assert property (pready |=> !pready)
      else $error("ready longer than one cycle");
   slverr_map_a: assert property (pready |-> pslverr == (paddr != 12'h0d4))
      else $error("error flag wrong for address");
   reserved_zero_a: assert property (pready && !pwrite |-> prdata[31:5] == 0 && prdata[3:2] == 0)
      else $error("reserved bits read nonzero");
   block_unlock_a: assert property (unlock_s |-> irq_block)
      else $error("unlock did not block");
   block_hold_a: assert property (unlock_s |-> irq_block [*3])
      else $error("block dropped early");
   // A lock bit may keep blocking on its own, so a release is only demanded with both unprogrammed.
   block_release_a: assert property ((unlock_s ##1 (!(pready && pwrite)) [*5]) |->
      !irq_block || !app_section_lock_b2 || !boot_section_lock_b2)
      else $error("block held past window");
   sel_guard_a: assert property ($changed(vector_base_select) |-> $past(irq_block))
      else $error("select changed outside window");
   vec_app_a: assert property (!vector_base_select && !$past(vector_base_select) |->
      vector_base_addr == 14'h0002)
      else $error("vector start wrong");
endmodule // vtp_ctrl_monitor

bind vtp_ctrl vtp_ctrl_monitor vtp_ctrl_monitor_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
   .prdata, .pready, .pslverr, .app_section_lock_b2, .boot_section_lock_b2, .irq_block, .vector_base_select,
   .vector_base_addr);

// ---- tb/vtp_ctrl_bench.sv ----
`timescale 1ns/1ps
`include "vtp_defines.vh"
module vtp_ctrl_bench;
   logic        pclk = 0;
   logic        presetn = 0;
   logic        psel = 0;
   logic        penable = 0;
   logic        pwrite = 0;
   logic [11:0] paddr = 0;
   logic [31:0] pwdata = 0;
   logic [1:0]  boot_size_fuses = 0;
   logic        boot_reset_fuse = 1;
   logic        app_section_lock_b2 = 1;
   logic        boot_section_lock_b2 = 1;
   logic        exec_in_boot = 0;
   logic        instr_done = 0;
   logic [31:0] rd;
   logic [31:0] d;
   logic        er;
   logic        held = 0;
   wire  [31:0] prdata;
   wire         pready, pslverr, irq_block, pullup_disable, vector_base_select;
   wire  [13:0] vector_base_addr, reset_addr;
   integer      errors = 0, checks_done = 0, seed = 32'h7620295d, i, n;
   always #10 pclk = ~pclk;
   vtp_ctrl vtp_ctrl_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
      .boot_size_fuses, .boot_reset_fuse, .app_section_lock_b2, .boot_section_lock_b2, .exec_in_boot, .instr_done,
      .irq_block, .pullup_disable, .vector_base_select, .vector_base_addr, .reset_addr);
   task results;
      if (errors == 0 && checks_done > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   task chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         errors++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // Keeping psel up lets a select write land inside the short unlock window.
   task apb(input logic w, input logic [11:0] a, input logic [31:0] wd, input logic keep);
      if (!held)
         psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (!pready && n < 20);
      if (!pready) begin
         errors++;
         results;
      end
      rd = prdata;
      er = pslverr;
      penable <= 0;
      held = keep;
      if (!keep) begin
         psel <= 0;
         @(posedge pclk);
      end
   endtask
   function logic [13:0] bstart(input logic [1:0] c);
      logic [14:0] w;
      w = c == 0 ? `VTP_BOOT_WORDS_SZ0 : c == 1 ? `VTP_BOOT_WORDS_SZ1 : c == 2 ? `VTP_BOOT_WORDS_SZ2 :
         `VTP_BOOT_WORDS_SZ3;
      return 14'(`VTP_FLASH_WORDS - w);
   endfunction
   task instr;
      instr_done <= 1;
      @(posedge pclk);
      instr_done <= 0;
   endtask
   initial begin
      repeat (16) @(posedge pclk);
      presetn <= 1;
      // Fuse inputs pass a synchroniser, so they get six edges to settle.
      repeat (6) @(posedge pclk);
      chk(vector_base_addr, 32'h2);
      chk(reset_addr, 32'h0);
      apb(0, 12'h0d4, 0, 0);
      chk(rd, 32'h0);
      apb(1, 12'h035, 32'hff, 0);
      chk(er, 1);
      for (i = 0; i < 8; i++) begin
         d = $random(seed);
         d[0] = 0;
         apb(1, 12'h0d4, d, 0);
         apb(0, 12'h0d4, 0, 0);
         chk(rd, {27'h0, d[4], 4'h0});
         chk(pullup_disable, d[4]);
      end
      apb(1, 12'h0d4, 32'h1, 0);
      chk(irq_block, 1);
      repeat (6) @(posedge pclk);
      chk(irq_block, 0);
      apb(0, 12'h0d4, 0, 0);
      chk(rd & 32'h3, 32'h0);
      for (i = 0; i < 4; i++) begin
         boot_size_fuses <= i[1:0];
         repeat (6) @(posedge pclk);
         apb(1, 12'h0d4, 32'h1, 1);
         apb(1, 12'h0d4, 32'h2, 0);
         repeat (3) @(posedge pclk);
         chk(irq_block, 1);
         chk(vector_base_select, 1);
         chk(vector_base_addr, bstart(i[1:0]) + 2);
         instr;
         repeat (2) @(posedge pclk);
         chk(irq_block, 0);
      end
      boot_reset_fuse <= 0;
      boot_size_fuses <= 2'h1;
      app_section_lock_b2 <= 0;
      repeat (6) @(posedge pclk);
      chk(reset_addr, 32'h3c00);
      chk(irq_block, 1);
      exec_in_boot <= 1;
      repeat (2) @(posedge pclk);
      chk(irq_block, 0);
      app_section_lock_b2 <= 1;
      apb(1, 12'h0d4, 32'h1, 1);
      apb(1, 12'h0d4, 32'h0, 0);
      instr;
      boot_section_lock_b2 <= 0;
      repeat (6) @(posedge pclk);
      chk(irq_block, 1);
      chk(vector_base_addr, 32'h2);
      exec_in_boot <= 0;
      repeat (2) @(posedge pclk);
      chk(irq_block, 0);
      results;
   end
endmodule // vtp_ctrl_bench
